/* verilog/spi_link_pkg.sv */
/*
 * shared constants for the serial register link: register map of the
 * sensor die, control byte fields, chopper settings, link timing and the
 * register map of the bus-side controller.
 * assumes one 50 MHz clock on both ends.
 */
package spi_link_pkg;

    // ----------------------------------------------------------------
    // sensor die register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [4:0] ADDR_CUR_HI = 5'h00;
    localparam logic [4:0] ADDR_CUR_LO = 5'h01;
    localparam logic [4:0] ADDR_VOLT_HI = 5'h02;
    localparam logic [4:0] ADDR_VOLT_LO = 5'h03;
    localparam logic [4:0] ADDR_FLAGS = 5'h04;
    localparam logic [4:0] ADDR_DECIM_CTRL = 5'h05;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] DECIM_CTRL_RESET = 8'h45;
    localparam int HDR_CMD_BIT = 7;
    localparam int DECIM_RATE_BIT = 7;
    localparam int CHOP_SEL_LSB = 5;

    // ----------------------------------------------------------------
    // chopper divider settings, half periods in oversampling ticks
    // ----------------------------------------------------------------
    localparam logic [1:0] CHOP_HIGH = 2'h0;
    localparam logic [1:0] CHOP_DIV256 = 2'h1;
    localparam logic [1:0] CHOP_DIV512 = 2'h2;
    localparam logic [9:0] CHOP_HALF_256 = 10'h080;
    localparam logic [9:0] CHOP_HALF_512 = 10'h100;
    localparam logic [9:0] CHOP_HALF_1024 = 10'h200;

    // ----------------------------------------------------------------
    // link timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCLK_HALF_NS = 2000;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // bus-side controller registers
    // ----------------------------------------------------------------
    localparam logic [7:0] HOST_CTRL = 8'h00;
    localparam logic [7:0] HOST_TXDATA = 8'h04;
    localparam logic [7:0] HOST_RXDATA = 8'h08;
    localparam logic [7:0] HOST_STATUS = 8'h0C;
    localparam logic [7:0] HOST_IRQ_STATUS = 8'h10;
    localparam logic [7:0] HOST_IRQ_MASK = 8'h14;
    localparam int CTRL_LEN_LSB = 8;
    localparam int CTRL_CPOL_BIT = 10;
    localparam int CTRL_START_BIT = 16;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_SETUP = 3'h1,
        ST_LEAD = 3'h3,
        ST_HOLD = 3'h2,
        ST_SETTLE = 3'h6,
        ST_TAIL = 3'h7
    } host_state_t;

endpackage

/* verilog/spi_link_if.sv */
/*
 * four-wire link between the bus-side controller and the sensor die.
 * assumes the data-out line is pulled low while the die leaves it free.
 */
`timescale 1ns/100ps
interface spi_link_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_line;

    // line level seen by the master
    assign miso_line = miso_oe & miso;

    modport device (input cs_n, input sclk, input mosi, output miso, output miso_oe);
    modport host (output cs_n, output sclk, output mosi, input miso_line);
endinterface

/* verilog/spi_reg_slave.sv */
/*
 * sensor die end of the link: frame decoder, result and status
 * registers, decimation control byte and chopper clock divider.
 * assumes link pins are asynchronous to hclk and far slower than it;
 * oversampling_tick is a one-cycle pulse on hclk.
 */
`timescale 1ns/100ps
module spi_reg_slave
    import spi_link_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    spi_link_if.device link,
    input wire logic [15:0] current_result,
    input wire logic current_update,
    input wire logic [15:0] voltage_result,
    input wire logic voltage_update,
    input wire logic [4:0] mode_flags,
    input wire logic oversampling_tick,
    output logic decim_rate_128,
    output logic chopper_clock
);

    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [1:0] cs_s_q;
    logic [1:0] sclk_s_q;
    logic [1:0] mosi_s_q;
    logic cs_prev_q;
    logic sclk_prev_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cs_s_q <= 2'h3;
            sclk_s_q <= 2'h0;
            mosi_s_q <= 2'h0;
            cs_prev_q <= 1'b1;
            sclk_prev_q <= 1'b0;
        end
        else
        begin
            cs_s_q <= {cs_s_q[0], link.cs_n};
            sclk_s_q <= {sclk_s_q[0], link.sclk};
            mosi_s_q <= {mosi_s_q[0], link.mosi};
            cs_prev_q <= cs_s_q[1];
            sclk_prev_q <= sclk_s_q[1];
        end
    end

    wire selected = ~cs_s_q[1];
    wire cs_fall = cs_prev_q & ~cs_s_q[1];
    wire sclk_rise = ~sclk_prev_q & sclk_s_q[1];
    wire sclk_fall = sclk_prev_q & ~sclk_s_q[1];

    // ----------------------------------------------------------------
    // clock polarity, fixed for the whole frame
    // ----------------------------------------------------------------
    logic pol_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pol_q <= 1'b0;
        else if (cs_fall)
            pol_q <= sclk_s_q[1];
    end

    // edges in the select cycle itself are ignored: polarity is not yet valid
    wire sample_edge = selected & ~cs_fall & (pol_q ? sclk_rise : sclk_fall);
    wire transfer_edge = selected & ~cs_fall & (pol_q ? sclk_fall : sclk_rise);

    // ----------------------------------------------------------------
    // frame decoder
    // ----------------------------------------------------------------
    logic [2:0] bit_cnt_q;
    logic [7:0] rx_q;
    logic hdr_done_q;
    logic is_read_q;
    logic [4:0] ptr_q;

    wire [7:0] rx_byte = {rx_q[6:0], mosi_s_q[1]};
    wire byte_done = sample_edge & (bit_cnt_q == 3'h7);
    wire [4:0] next_ptr = ptr_q + 5'h01;
    wire hdr_read = rx_byte[HDR_CMD_BIT];
    wire [4:0] rd_addr = hdr_done_q ? next_ptr : rx_byte[4:0];
    wire load_tx = byte_done & (hdr_done_q ? is_read_q : hdr_read);
    wire wr_en = byte_done & hdr_done_q & ~is_read_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bit_cnt_q <= 3'h0;
            rx_q <= 8'h00;
        end
        else if (cs_fall)
            bit_cnt_q <= 3'h0;
        else if (sample_edge)
        begin
            rx_q <= rx_byte;
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hdr_done_q <= 1'b0;
            is_read_q <= 1'b0;
            ptr_q <= 5'h00;
        end
        else if (cs_fall)
            hdr_done_q <= 1'b0;
        else if (byte_done && !hdr_done_q)
        begin
            hdr_done_q <= 1'b1;
            is_read_q <= hdr_read;
            ptr_q <= rx_byte[4:0];
        end
        else if (byte_done)
            ptr_q <= next_ptr;
    end

    // ----------------------------------------------------------------
    // read-back shifter
    // ----------------------------------------------------------------
    logic [7:0] tx_q;
    logic miso_q;
    logic [7:0] rd_data;
    logic flags_loaded_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_q <= 8'h00;
            miso_q <= 1'b0;
            flags_loaded_q <= 1'b0;
        end
        else if (cs_fall || !selected)
        begin
            tx_q <= 8'h00;
            miso_q <= 1'b0;
            flags_loaded_q <= 1'b0;
        end
        else if (load_tx)
        begin
            tx_q <= rd_data;
            flags_loaded_q <= rd_addr == ADDR_FLAGS;
        end
        else if (transfer_edge)
        begin
            miso_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    assign link.miso = miso_q;
    assign link.miso_oe = selected;

    // ----------------------------------------------------------------
    // result and status registers
    // ----------------------------------------------------------------
    logic [15:0] cur_q;
    logic [15:0] volt_q;
    logic [4:0] mode_q;
    logic cur_new_q;
    logic volt_new_q;
    logic [7:0] decim_q;

    // a result may change between the reads of its two bytes; read in one burst
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cur_q <= {RESULT_RESET, RESULT_RESET};
            volt_q <= {RESULT_RESET, RESULT_RESET};
        end
        else
        begin
            if (current_update)
                cur_q <= current_result;
            if (voltage_update)
                volt_q <= voltage_result;
        end
    end

    wire flags_read = byte_done & flags_loaded_q;
    wire [7:0] flags = {mode_q, cur_new_q, volt_new_q, 1'b0};

    // fresh bits clear only after a whole status byte went out, not on a prefetch; a new result wins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_q <= FLAGS_RESET[7:3];
            cur_new_q <= FLAGS_RESET[2];
            volt_new_q <= FLAGS_RESET[1];
        end
        else
        begin
            mode_q <= mode_flags;
            cur_new_q <= current_update | (cur_new_q & ~flags_read);
            volt_new_q <= voltage_update | (volt_new_q & ~flags_read);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            decim_q <= DECIM_CTRL_RESET;
        else if (wr_en && ptr_q == ADDR_DECIM_CTRL)
            decim_q <= rx_byte;
    end

    always_comb
    begin
        unique case (rd_addr)
            ADDR_CUR_HI: rd_data = cur_q[15:8];
            ADDR_CUR_LO: rd_data = cur_q[7:0];
            ADDR_VOLT_HI: rd_data = volt_q[15:8];
            ADDR_VOLT_LO: rd_data = volt_q[7:0];
            ADDR_FLAGS: rd_data = flags;
            ADDR_DECIM_CTRL: rd_data = decim_q;
            default: rd_data = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // decimation select and chopper clock
    // ----------------------------------------------------------------
    logic [9:0] chop_cnt_q;
    logic chop_q;

    assign decim_rate_128 = decim_q[DECIM_RATE_BIT];
    wire [1:0] chop_sel = decim_q[CHOP_SEL_LSB +: 2];

    function automatic logic [9:0] chop_half(input logic [1:0] sel);
        unique case (sel)
            CHOP_DIV256: chop_half = CHOP_HALF_256;
            CHOP_DIV512: chop_half = CHOP_HALF_512;
            default: chop_half = CHOP_HALF_1024;
        endcase
    endfunction

    wire chop_wrap = chop_cnt_q >= chop_half(chop_sel) - 10'h001;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            chop_cnt_q <= 10'h000;
            chop_q <= 1'b1;
        end
        else if (chop_sel == CHOP_HIGH)
        begin
            chop_cnt_q <= 10'h000;
            chop_q <= 1'b1;
        end
        else if (oversampling_tick)
        begin
            chop_cnt_q <= chop_wrap ? 10'h000 : chop_cnt_q + 10'h001;
            if (chop_wrap)
                chop_q <= ~chop_q;
        end
    end

    assign chopper_clock = chop_q;

endmodule // spi_reg_slave

/* verilog/spi_master_ctrl.sv */
/*
 * bus-side end of the link: AHB-Lite register slave that runs one frame
 * of a header byte plus one to four data bytes and raises an interrupt.
 * assumes the sensor die answers within one half period of its clock.
 */
`timescale 1ns/100ps
module spi_master_ctrl
    import spi_link_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_CYC
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    spi_link_if.host link
);

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    host_state_t state_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic [7:0] hdr_q;
    logic [1:0] len_q;
    logic [31:0] tx_word_q;
    logic [31:0] rx_word_q;
    logic done_q;
    logic mask_q;
    logic done_set;

    wire take = hsel & htrans[1] & hready;
    wire rd_take = take & ~hwrite;
    wire busy = state_q != ST_IDLE;
    wire wr_ctrl = wr_pend_q & (wr_addr_q == HOST_CTRL);
    wire start = wr_ctrl & hwdata[CTRL_START_BIT] & ~busy;
    wire irq_clr = rd_take & (haddr[7:0] == HOST_IRQ_STATUS);

    function automatic logic [31:0] reg_read(input logic [7:0] a);
        unique case (a)
            HOST_CTRL: reg_read = {21'h0, link.sclk & ~busy, len_q, hdr_q};
            HOST_TXDATA: reg_read = tx_word_q;
            HOST_RXDATA: reg_read = rx_word_q;
            HOST_STATUS: reg_read = {31'h0, busy};
            HOST_IRQ_STATUS: reg_read = {31'h0, done_q};
            HOST_IRQ_MASK: reg_read = {31'h0, mask_q};
            default: reg_read = 32'h0;
        endcase
    endfunction

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q <= 32'h0;
        end
        else
        begin
            wr_pend_q <= take & hwrite;
            wr_addr_q <= haddr[7:0];
            if (rd_take)
                hrdata_q <= reg_read(haddr[7:0]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hdr_q <= 8'h00;
            len_q <= 2'h0;
            tx_word_q <= 32'h0;
            mask_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            if (wr_ctrl && !busy)
            begin
                hdr_q <= hwdata[7:0];
                len_q <= hwdata[CTRL_LEN_LSB +: 2];
            end
            if (wr_pend_q && wr_addr_q == HOST_TXDATA && !busy)
                tx_word_q <= hwdata;
            if (wr_pend_q && wr_addr_q == HOST_IRQ_MASK)
                mask_q <= hwdata[0];
            done_q <= done_set | (done_q & ~irq_clr);
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = done_q & mask_q;

    // ----------------------------------------------------------------
    // frame engine
    // ----------------------------------------------------------------
    logic [15:0] cnt_q;
    logic cs_n_q;
    logic sclk_q;
    logic mosi_q;
    logic [39:0] shift_q;
    logic [2:0] bit_q;
    logic [2:0] byte_q;
    logic [7:0] rxb_q;
    logic [1:0] miso_s_q;

    wire expired = cnt_q == 16'h0;
    wire [7:0] rx_byte = {rxb_q[6:0], miso_s_q[1]};
    wire last_bit = (bit_q == 3'h7) & (byte_q == {1'b0, len_q} + 3'h1);
    wire [15:0] half_m1 = 16'(HALF_CYC - 1);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            miso_s_q <= 2'h0;
        else
            miso_s_q <= {miso_s_q[0], link.miso_line};
    end

    assign done_set = (state_q == ST_TAIL) & expired;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 16'h0;
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
            mosi_q <= 1'b0;
            shift_q <= 40'h0;
            bit_q <= 3'h0;
            byte_q <= 3'h0;
            rxb_q <= 8'h00;
            rx_word_q <= 32'h0;
        end
        else
        begin
            cnt_q <= expired ? half_m1 : cnt_q - 16'h1;
            unique case (state_q)
                ST_IDLE:
                begin
                    cnt_q <= half_m1;
                    if (start)
                    begin
                        // idle level set a half period before select falls
                        sclk_q <= hwdata[CTRL_CPOL_BIT];
                        shift_q <= {hwdata[7:0], tx_word_q[7:0], tx_word_q[15:8],
                                    tx_word_q[23:16], tx_word_q[31:24]};
                        bit_q <= 3'h0;
                        byte_q <= 3'h0;
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP:
                    if (expired)
                    begin
                        cs_n_q <= 1'b0;
                        state_q <= ST_LEAD;
                    end
                ST_LEAD, ST_SETTLE:
                    if (expired)
                    begin
                        sclk_q <= ~sclk_q;
                        mosi_q <= shift_q[39];
                        shift_q <= {shift_q[38:0], 1'b0};
                        state_q <= ST_HOLD;
                    end
                ST_HOLD:
                    if (expired)
                    begin
                        sclk_q <= ~sclk_q;
                        rxb_q <= rx_byte;
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7)
                        begin
                            byte_q <= byte_q + 3'h1;
                            for (int i = 0; i < 4; i++)
                                if (byte_q == 3'(i + 1))
                                    rx_word_q[8 * i +: 8] <= rx_byte;
                        end
                        state_q <= last_bit ? ST_TAIL : ST_SETTLE;
                    end
                ST_TAIL:
                    if (expired)
                    begin
                        cs_n_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    assign link.cs_n = cs_n_q;
    assign link.sclk = sclk_q;
    assign link.mosi = mosi_q;

endmodule // spi_master_ctrl

/* tb/spi_link_assertions.sv */
/*
 * link checker: frame shape, edge discipline and data-out enable.
 * assumes it watches the interface joining the two design ends.
 */
`timescale 1ns/100ps
module spi_link_assertions
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    logic cs_q;
    logic sclk_q;
    logic pol_q;
    logic [6:0] edges_q;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ------------------------------------------------------------
    // helper: idle level at select fall, clock edges in the frame
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cs_q <= 1'b1;
            sclk_q <= 1'b0;
            pol_q <= 1'b0;
            edges_q <= 7'h00;
        end
        else
        begin
            cs_q <= cs_n;
            sclk_q <= sclk;
            if (cs_q && !cs_n)
            begin
                pol_q <= sclk;
                edges_q <= 7'h00;
            end
            else if (!cs_n && (sclk != sclk_q))
            begin
                edges_q <= edges_q + 7'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_sclk_setup_select: assert property ($fell(cs_n) |-> $past(cs_n, 3) && $stable(sclk))
        else $error("clock not settled before select");
    a_sclk_hold_select: assert property ($fell(cs_n) |=> $stable(sclk) [*3])
        else $error("clock moved right after select");
    a_frame_ends_idle: assert property ($rose(cs_n) |-> sclk == pol_q)
        else $error("frame ended off the idle level");
    a_frame_whole_bytes: assert property ($rose(cs_n) |->
        edges_q[3:0] == 4'h0 && edges_q >= 7'h20 && edges_q <= 7'h50)
        else $error("frame is not whole bytes");
    a_mosi_transfer_edge: assert property (!cs_n && !cs_q && $changed(mosi) |-> sclk != pol_q)
        else $error("master data moved in sample half");
    a_miso_transfer_edge: assert property (miso_oe && $past(miso_oe) && $changed(miso) |-> sclk != pol_q)
        else $error("slave data moved in sample half");
    a_select_drives_out: assert property ($fell(cs_n) |-> ##[1:4] miso_oe)
        else $error("data out not enabled after select");
    a_deselect_frees_out: assert property ($rose(cs_n) |-> ##[1:4] !miso_oe)
        else $error("data out not released");
endmodule // spi_link_assertions

/* tb/tb_spi_register_access_adc_data.sv */
/*
 * bench: bus-side controller and sensor die joined over the link.
 * assumes the one bus slave returns its own ready as hready.
 */
`timescale 1ns/100ps
module tb_spi_register_access_adc_data
    import spi_link_pkg::*;
;
    localparam int HALF = 8;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic [15:0] cur;
    logic cur_up;
    logic [15:0] volt;
    logic volt_up;
    logic [4:0] flags;
    logic tick;
    logic decim;
    logic chop;
    logic mask;
    logic [31:0] rd;
    int n_errors;
    int samples_checked;
    int cyc;

    spi_link_if spi_link_if_i();
    spi_master_ctrl #(.HALF_CYC(HALF)) spi_master_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .link(spi_link_if_i.host));
    spi_reg_slave spi_reg_slave_i (.hclk(hclk), .hresetn(hresetn), .link(spi_link_if_i.device),
        .current_result(cur), .current_update(cur_up), .voltage_result(volt), .voltage_update(volt_up),
        .mode_flags(flags), .oversampling_tick(tick), .decim_rate_128(decim), .chopper_clock(chop));
    spi_link_assertions spi_link_assertions_i (.hclk(hclk), .hresetn(hresetn), .cs_n(spi_link_if_i.cs_n),
        .sclk(spi_link_if_i.sclk), .mosi(spi_link_if_i.mosi), .miso(spi_link_if_i.miso),
        .miso_oe(spi_link_if_i.miso_oe));

    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // a hang in a frame or a wait lands here
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_errors = n_errors + 1;
            end_of_test();
        end
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked = samples_checked + 1;
        if (g !== e)
        begin
            n_errors = n_errors + 1;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    // one frame; only the bytes it carried are compared on reads
    task frame(input logic [7:0] hdr, input logic [1:0] len, input logic pol, input logic [31:0] tx,
        input logic [31:0] e);
        int n;
        ahb(1'b1, HOST_TXDATA, tx);
        ahb(1'b1, HOST_CTRL, {15'h0, 1'b1, 5'h0, pol, len, hdr});
        n = 0;
        rd = 32'h1;
        while (rd[0] === 1'b1 && n < 400)
        begin
            ahb(1'b0, HOST_STATUS, 32'h0);
            n = n + 1;
        end
        chk("irq", {31'h0, mask}, {31'h0, irq});
        ahb(1'b0, HOST_IRQ_STATUS, 32'h0);
        chk("done", 32'h1, rd & 32'h1);
        chk("irq_clear", 32'h0, {31'h0, irq});
        ahb(1'b0, HOST_RXDATA, 32'h0);
        if (hdr[7])
            chk("rxdata", e, rd & ~(32'hFFFFFFFF << (8 * len + 8)));
    endtask

    task tick1();
        tick <= 1'b1;
        @(posedge hclk);
        tick <= 1'b0;
        @(posedge hclk);
    endtask

    // ticks between two chopper toggles; 600 means it never toggled
    task chop_half(input logic [31:0] e);
        int n;
        logic c;
        c = chop;
        n = 0;
        while (chop === c && n < 600)
        begin
            tick1();
            n = n + 1;
        end
        c = chop;
        n = 0;
        while (chop === c && n < 600)
        begin
            tick1();
            n = n + 1;
        end
        chk("chop_half", e, n);
    endtask

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        cur = 16'h0;
        cur_up = 1'b0;
        volt = 16'h0;
        volt_up = 1'b0;
        flags = 5'h00;
        tick = 1'b0;
        mask = 1'b0;
        n_errors = 0;
        samples_checked = 0;
        cyc = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("decim", 32'h0, {31'h0, decim});
        chk("chop", 32'h1, {31'h0, chop});
        ahb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        frame(8'h80, 2'h0, 1'b0, 32'h0, 32'h0);
        frame(8'h82, 2'h3, 1'b1, 32'h0, 32'h45000000);
        mask = 1'b1;
        ahb(1'b1, HOST_IRQ_MASK, 32'h1);
        cur <= 16'hA55A;
        volt <= 16'h3CC3;
        flags <= 5'h16;
        cur_up <= 1'b1;
        volt_up <= 1'b1;
        @(posedge hclk);
        cur_up <= 1'b0;
        volt_up <= 1'b0;
        @(posedge hclk);
        frame(8'h80, 2'h3, 1'b0, 32'h0, 32'hC33C5AA5);
        frame(8'h84, 2'h0, 1'b1, 32'h0, 32'h000000B6);
        frame(8'h84, 2'h0, 1'b0, 32'h0, 32'h000000B0);
        chop_half(32'h100);
        frame(8'h03, 2'h2, 1'b1, 32'h00A0FFFF, 32'h0);
        frame(8'h83, 2'h2, 1'b0, 32'h0, 32'h00A0B0C3);
        chk("decim", 32'h1, {31'h0, decim});
        chop_half(32'h80);
        frame(8'h05, 2'h0, 1'b1, 32'h00000060, 32'h0);
        frame(8'h85, 2'h0, 1'b0, 32'h0, 32'h00000060);
        chop_half(32'h200);
        frame(8'h05, 2'h0, 1'b0, 32'h0000001F, 32'h0);
        chk("decim", 32'h0, {31'h0, decim});
        chop_half(32'h258);
        chk("chop", 32'h1, {31'h0, chop});
        end_of_test();
    end
endmodule // tb_spi_register_access_adc_data
